/* hw/mgmt_bit_bank.sv */
// Management register bank showing each special bit behaviour of a transceiver.
// Assumes strobes from a management frame engine, one cycle each, synchronous to core_clk_i.
`timescale 1ns/1ps

// Operation
// [RULE_01] Every register bit with a default is loaded with it whenever reset is applied.
// [RULE_02] Defaults are none, zero, one, or a pin level captured while reset is held.
// [RULE_03] The host leaves reserved bits at their defaults; they read zero and ignore writes.
// [RULE_04] The latch-high bit sets on its monitored signal and holds until reset or a read.
// [RULE_05] A read of the latch-high bit reloads it with the live signal level.
// [RULE_06] The latch-low bit clears on its active-low signal and holds until reset or a read.
// [RULE_07] A read of the latch-low bit reloads it with the live signal level.
// [RULE_08] The latch-max field captures the tracked state only when it exceeds the held value.
// [RULE_09] A read of the latch-max field reloads it with the live state value.
// [RULE_10] The self-clear bit resets to zero and a written one starts its function.
// [RULE_11] The self-clear bit drops to zero on its own when the function finishes.
// [RULE_12] Override-write bits change only while the enable is set; the next write clears it.
// [RULE_13] Read-only bits ignore writes and read/write bits take any written value.
// [RULE_14] The write-zero-only bit accepts a written zero and ignores a written one.
// [RULE_15] A completed read frame gives a per-register read strobe that reloads latching bits.
module mgmt_bit_bank
  import mgmt_bits_pkg::*;
(
  input wire logic core_clk_i,                // Core clock, 10 MHz.
  input wire logic rstn_i,                    // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] reg_addr_i,   // Register address of the frame.
  input wire logic wr_stb_i,                  // Completed write frame, one-cycle pulse.
  input wire logic [DATA_W-1:0] wr_data_i,    // Write data of the frame.
  input wire logic rd_stb_i,                  // Completed read frame, one-cycle pulse.
  input wire logic strap_i,                   // Strap pin captured at reset.
  input wire logic event_hi_i,                // Monitored active-high event.
  input wire logic event_lo_n_i,              // Monitored active-low event.
  input wire logic [MAX_W-1:0] sm_state_i,    // Tracked state machine value.
  input wire logic func_done_i,               // Triggered function finished.
  input wire logic fault_i,                   // Sets the write-zero-only bit.
  output logic [DATA_W-1:0] rd_data_o,        // Read data of the last read.
  output logic rd_valid_o,                    // Read data valid, one-cycle pulse.
  output logic func_start_o,                  // Starts the triggered function, pulse.
  output logic func_busy_o,                   // Self-clear bit, function running.
  output logic [RW_W-1:0] rw_field_o,         // Plain read/write control field.
  output logic [CW_W-1:0] cw_field_o,         // Override-write control field.
  output logic strap_o                        // Strap value held since reset.
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic trig;
    logic [RW_W-1:0] rw;
    logic strap;
    logic lh;
    logic ll;
    logic [MAX_W-1:0] latch_max_field;
    logic ovr_en;
    logic [CW_W-1:0] cw;
    logic w0;
    logic start;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    trig: TRIG_RST,
    rw: RW_RST,
    strap: 1'h0,
    lh: LH_RST,
    ll: LL_RST,
    latch_max_field: MAX_RST,
    ovr_en: OVR_EN_RST,
    cw: CW_RST,
    w0: W0_RST,
    start: 1'h0,
    rvalid: 1'h0,
    rdata: RDATA_RST
  };

  state_t q;
  state_t d;
  logic wr_cfg;
  logic wr_ext;
  logic rd_stat;
  logic [RW_W-1:0] wr_rw_field;
  logic [CW_W-1:0] wr_cw_field;

  // ==========================================================================
  // Per-register strobes
  assign wr_cfg = wr_stb_i && (reg_addr_i == CFG_ADDR);
  assign wr_ext = wr_stb_i && (reg_addr_i == EXT_ADDR);
  assign rd_stat = rd_stb_i && (reg_addr_i == STAT_ADDR); // see [RULE_15]
  // Write-data field slices, named so that the checks can look at their past values.
  assign wr_rw_field = wr_data_i[CFG_RW_HI:CFG_RW_LO];
  assign wr_cw_field = wr_data_i[EXT_CW_HI:EXT_CW_LO];

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.rvalid = rd_stb_i; // see [RULE_15]

    // The reload takes the live level, so an event in the read cycle is kept.
    if (rd_stat) begin
      d.lh = event_hi_i; // see [RULE_05]
      d.ll = event_lo_n_i; // see [RULE_07]
      d.latch_max_field = sm_state_i; // see [RULE_09]
    end else begin
      d.lh = q.lh | event_hi_i; // see [RULE_04]
      d.ll = q.ll & event_lo_n_i; // see [RULE_06]
      if (sm_state_i > q.latch_max_field) begin
        d.latch_max_field = sm_state_i; // see [RULE_08]
      end
    end

    // A new trigger is ignored while the function is still running.
    if (q.trig && func_done_i) begin
      d.trig = 1'b0; // see [RULE_11]
    end
    if (wr_cfg && wr_data_i[CFG_TRIG_BIT] && !q.trig) begin
      d.trig = 1'b1; // see [RULE_10]
      d.start = 1'b1;
    end
    if (wr_cfg) begin
      d.rw = wr_rw_field; // see [RULE_13]
    end

    // Any write consumes the enable; only the write that follows it may change the field.
    if (wr_stb_i) begin
      d.ovr_en = 1'b0; // see [RULE_12]
    end
    if (wr_ext && q.ovr_en) begin
      d.cw = wr_cw_field; // see [RULE_12]
    end
    if (wr_ext && !q.ovr_en && wr_data_i[EXT_OVR_EN_BIT]) begin
      d.ovr_en = 1'b1;
    end

    // A fault in the clearing cycle wins over the host's zero.
    if (wr_ext && !wr_data_i[EXT_W0_BIT]) begin
      d.w0 = 1'b0; // see [RULE_14]
    end
    if (fault_i) begin
      d.w0 = 1'b1;
    end

    // Read data shows the values held before this read; reserved bits read zero.
    if (rd_stb_i) begin
      d.rdata = RESERVED_VAL;
      unique case (reg_addr_i)
        CFG_ADDR: begin
          d.rdata[CFG_TRIG_BIT] = q.trig;
          d.rdata[CFG_RW_HI:CFG_RW_LO] = q.rw;
          d.rdata[CFG_STRAP_BIT] = q.strap;
        end
        STAT_ADDR: begin
          d.rdata[STAT_LH_BIT] = q.lh;
          d.rdata[STAT_LL_BIT] = q.ll;
          d.rdata[STAT_MAX_HI:STAT_MAX_LO] = q.latch_max_field;
        end
        EXT_ADDR: begin
          d.rdata[EXT_OVR_EN_BIT] = q.ovr_en;
          d.rdata[EXT_CW_HI:EXT_CW_LO] = q.cw;
          d.rdata[EXT_W0_BIT] = q.w0;
        end
        default: begin
          d.rdata = RESERVED_VAL;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q <= STATE_RST; // see [RULE_01]
      q.strap <= strap_i; // see [RULE_02]
    end else begin
      q <= d;
    end
  end

  assign rd_data_o = q.rdata;
  assign rd_valid_o = q.rvalid;
  assign func_start_o = q.start;
  assign func_busy_o = q.trig;
  assign rw_field_o = q.rw;
  assign cw_field_o = q.cw;
  assign strap_o = q.strap;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  reset_defaults_a: assert property (disable iff (1'b0) !rstn_i |=> // see [RULE_01]
    (q.ll == LL_RST && q.lh == LH_RST && q.trig == TRIG_RST && q.cw == CW_RST
     && q.strap == $past(strap_i)))
    else $error("Defaults not loaded by reset.");

  lh_hold_a: assert property (q.lh && !rd_stat |=> q.lh) // see [RULE_04]
    else $error("Latch-high bit lost before a read.");

  lh_reload_a: assert property (rd_stat |=> q.lh == $past(event_hi_i)) // see [RULE_05]
    else $error("Latch-high bit not reloaded after a read.");

  ll_hold_a: assert property (!q.ll && !rd_stat |=> !q.ll) // see [RULE_06]
    else $error("Latch-low bit lost before a read.");

  ll_reload_a: assert property (rd_stat |=> q.ll == $past(event_lo_n_i)) // see [RULE_07]
    else $error("Latch-low bit not reloaded after a read.");

  max_track_a: assert property (!rd_stat |=> // see [RULE_08]
    (q.latch_max_field >= $past(q.latch_max_field) && q.latch_max_field >= $past(sm_state_i)))
    else $error("Latch-max field fell or missed a larger value.");

  max_reload_a: assert property (rd_stat ##1 rd_stat |-> // see [RULE_09]
    ##1 rd_data_o[STAT_MAX_HI:STAT_MAX_LO] == $past(sm_state_i, 2))
    else $error("Second read does not show the live state.");

  trig_start_a: assert property (wr_cfg && wr_data_i[CFG_TRIG_BIT] && !q.trig |=> // see [RULE_10]
    (q.trig && func_start_o) ##1 !func_start_o)
    else $error("Trigger write did not start the function.");

  trig_done_a: assert property (q.trig && func_done_i |=> !q.trig) // see [RULE_11]
    else $error("Self-clear bit stayed set after completion.");

  ovr_gate_a: assert property (wr_ext && !q.ovr_en |=> q.cw == $past(q.cw)) // see [RULE_12]
    else $error("Override field changed without the enable.");

  ovr_clear_a: assert property (q.ovr_en && wr_stb_i |=> !q.ovr_en) // see [RULE_12]
    else $error("Override enable survived a write.");

  ro_keep_a: assert property (wr_stb_i |=> $stable(q.strap)) // see [RULE_13]
    else $error("Read-only bit changed on a write.");

  w0_keep_a: assert property (wr_ext && wr_data_i[EXT_W0_BIT] && !q.w0 && // see [RULE_14]
    !fault_i |=> !q.w0)
    else $error("Write-zero-only bit took a written one.");

  read_strobe_a: assert property (rd_stb_i |=> // see [RULE_15]
    rd_valid_o ##1 !rd_valid_o || $past(rd_stb_i))
    else $error("Read frame gave no read data strobe.");

  // ==========================================================================
  // Checks on the read path
  rd_hold_a: assert property (!rd_stb_i |=> $stable(rd_data_o)) // see [RULE_15]
    else $error("Read data changed without a read frame.");

  rvalid_idle_a: assert property (!rd_stb_i |=> !rd_valid_o) // see [RULE_15]
    else $error("Read data strobe without a read frame.");

  reserved_read_a: assert property (rd_stb_i && reg_addr_i != CFG_ADDR && // see [RULE_03]
    reg_addr_i != STAT_ADDR && reg_addr_i != EXT_ADDR |=> rd_data_o == RESERVED_VAL)
    else $error("Unmapped register did not read as reserved.");

  // ==========================================================================
  // Checks on the latching status bits
  lh_set_a: assert property (event_hi_i && !rd_stat |=> q.lh) // see [RULE_04]
    else $error("Latch-high bit missed its event.");

  ll_clear_a: assert property (!event_lo_n_i && !rd_stat |=> !q.ll) // see [RULE_06]
    else $error("Latch-low bit missed its event.");

  max_load_a: assert property (rd_stat |=> q.latch_max_field == $past(sm_state_i)) // see [RULE_09]
    else $error("Latch-max field not reloaded after a read.");

  max_keep_a: assert property (!rd_stat && sm_state_i <= q.latch_max_field |=> // see [RULE_08]
    $stable(q.latch_max_field))
    else $error("Latch-max field took a value that was not larger.");

  // ==========================================================================
  // Checks on the self-clearing trigger
  start_once_a: assert property (func_start_o |=> !func_start_o) // see [RULE_10]
    else $error("Start pulse lasted more than one cycle.");

  busy_write_a: assert property (wr_cfg && q.trig |=> !func_start_o) // see [RULE_10]
    else $error("Trigger write restarted a running function.");

  trig_hold_a: assert property (q.trig && !func_done_i |=> q.trig) // see [RULE_11]
    else $error("Self-clear bit dropped before completion.");

  // ==========================================================================
  // Checks on the control fields
  rw_write_a: assert property (wr_cfg |=> q.rw == $past(wr_rw_field)) // see [RULE_13]
    else $error("Read/write field did not take the written value.");

  rw_keep_a: assert property (!wr_cfg |=> $stable(q.rw)) // see [RULE_13]
    else $error("Read/write field changed without a write.");

  cw_write_a: assert property (wr_ext && q.ovr_en |=> // see [RULE_12]
    q.cw == $past(wr_cw_field))
    else $error("Override field did not take the enabled write.");

  cw_keep_a: assert property (!(wr_ext && q.ovr_en) |=> $stable(q.cw)) // see [RULE_12]
    else $error("Override field changed outside an enabled write.");

  ovr_set_a: assert property (wr_ext && !q.ovr_en && // see [RULE_12]
    wr_data_i[EXT_OVR_EN_BIT] |=> q.ovr_en)
    else $error("Override enable not set by its write.");

  ovr_hold_a: assert property (!wr_stb_i |=> $stable(q.ovr_en)) // see [RULE_12]
    else $error("Override enable changed without a write.");

  w0_clear_a: assert property (wr_ext && !wr_data_i[EXT_W0_BIT] && // see [RULE_14]
    !fault_i |=> !q.w0)
    else $error("Write-zero-only bit ignored a written zero.");

  w0_set_a: assert property (fault_i |=> q.w0) // see [RULE_14]
    else $error("Write-zero-only bit missed its fault.");

endmodule

/* hw/mgmt_bits_pkg.sv */
// Constants for the management register bit-behaviour bank.
// Assumes a management frame engine outside that delivers decoded read and write strobes.
package mgmt_bits_pkg;

  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Register addresses
  localparam logic [ADDR_W-1:0] CFG_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h01;
  localparam logic [ADDR_W-1:0] EXT_ADDR = 5'h10;

  // ==========================================================================
  // Field positions in the configuration register
  localparam int CFG_TRIG_BIT = 15;
  localparam int CFG_RW_HI = 14;
  localparam int CFG_RW_LO = 8;
  localparam int CFG_STRAP_BIT = 7;

  // ==========================================================================
  // Field positions in the status register
  localparam int STAT_LH_BIT = 15;
  localparam int STAT_LL_BIT = 14;
  localparam int STAT_MAX_HI = 13;
  localparam int STAT_MAX_LO = 11;

  // ==========================================================================
  // Field positions in the extended register
  localparam int EXT_OVR_EN_BIT = 15;
  localparam int EXT_CW_HI = 14;
  localparam int EXT_CW_LO = 12;
  localparam int EXT_W0_BIT = 11;

  // ==========================================================================
  // Field widths and reset values
  localparam int RW_W = CFG_RW_HI - CFG_RW_LO + 1;
  localparam int MAX_W = STAT_MAX_HI - STAT_MAX_LO + 1;
  localparam int CW_W = EXT_CW_HI - EXT_CW_LO + 1;
  localparam logic TRIG_RST = 1'h0;
  localparam logic [RW_W-1:0] RW_RST = 7'h00;
  localparam logic LH_RST = 1'h0;
  localparam logic LL_RST = 1'h1;
  localparam logic [MAX_W-1:0] MAX_RST = 3'h0;
  localparam logic OVR_EN_RST = 1'h0;
  localparam logic [CW_W-1:0] CW_RST = 3'h0;
  localparam logic W0_RST = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RESERVED_VAL = 16'h0000;

endpackage

/* sim/mgmt_host_model.sv */
// Host model: issues completed read and write frames to the bank as strobes.
// Assumes the bank answers a read with rd_valid_o within three cycles.
`timescale 1ns/1ps
module mgmt_host_model
  import mgmt_bits_pkg::*;
(
  input wire logic clk_i,                    // Core clock.
  input wire logic rd_valid_i,               // Read answer valid.
  input wire logic [DATA_W-1:0] rd_data_i,   // Read answer data.
  output logic [ADDR_W-1:0] addr_o,          // Frame address.
  output logic wr_stb_o,                     // Write frame strobe.
  output logic [DATA_W-1:0] wr_data_o,       // Write frame data.
  output logic rd_stb_o                      // Read frame strobe.
);
  initial begin
    addr_o = 5'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 16'h0000;
    rd_stb_o = 1'b0;
  end
  // Every caller keeps reserved bits at zero in each written word.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_data_o = d;
    wr_stb_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_stb_o = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_stb_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_stb_o = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rd_valid_i === 1'b1) begin
        d = rd_data_i;
        ok = 1'b1;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask
endmodule

/* sim/tb_top.sv */
// Testbench for the management bit bank: walks each special bit behaviour.
// Assumes the host model for frames; the bench models the triggered function.
`timescale 1ns/1ps
module tb_top;
  import mgmt_bits_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic strap_i = 1'b1;
  logic event_hi_i = 1'b0;
  logic event_lo_n_i = 1'b1;
  logic [MAX_W-1:0] sm_state_i = 3'h0;
  logic fault_i = 1'b0;
  logic func_done_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic wr_stb_i, rd_stb_i, rd_valid_o, func_start_o, func_busy_o, strap_o;
  logic [DATA_W-1:0] wr_data_i, rd_data_o;
  logic [RW_W-1:0] rw_field_o;
  logic [CW_W-1:0] cw_field_o;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int done_cnt = 0;
  int starts = 0;
  mgmt_bit_bank dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i), .rd_stb_i(rd_stb_i), .strap_i(strap_i),
    .event_hi_i(event_hi_i), .event_lo_n_i(event_lo_n_i), .sm_state_i(sm_state_i),
    .func_done_i(func_done_i), .fault_i(fault_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .func_start_o(func_start_o), .func_busy_o(func_busy_o),
    .rw_field_o(rw_field_o), .cw_field_o(cw_field_o), .strap_o(strap_o));
  mgmt_host_model host (.clk_i(core_clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .addr_o(reg_addr_i), .wr_stb_o(wr_stb_i), .wr_data_o(wr_data_i), .rd_stb_o(rd_stb_i));
  always #50 core_clk_i = ~core_clk_i;
  // The triggered function finishes five cycles after its start pulse.
  assign func_done_i = (done_cnt == 1);
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (func_start_o === 1'b1) begin
      starts <= starts + 1;
      done_cnt <= 5;
    end else if (done_cnt != 0) begin
      done_cnt <= done_cnt - 1;
    end
    if (cyc == 4000) begin
      miscompares++;
      $display("FAIL t=%0t timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    bit ok;
    host.rd(a, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(exp, d);
  endtask
  task automatic pulse_events();
    @(posedge core_clk_i);
    #1;
    event_hi_i = 1'b1;
    event_lo_n_i = 1'b0;
    sm_state_i = 3'h3;
    @(posedge core_clk_i);
    #1;
    event_hi_i = 1'b0;
    event_lo_n_i = 1'b1;
    sm_state_i = 3'h6;
    @(posedge core_clk_i);
    #1;
    sm_state_i = 3'h2;
  endtask
  task automatic t_defaults();
    chk({15'h0, strap_o}, 16'h0001);
    chk({9'h0, rw_field_o}, 16'h0000);
    rchk(CFG_ADDR, 16'h0080);
    rchk(STAT_ADDR, 16'h4000);
    rchk(EXT_ADDR, 16'h0000);
    rchk(5'h05, 16'h0000);
  endtask
  task automatic t_latches();
    pulse_events();
    rchk(STAT_ADDR, 16'hb000);
    rchk(STAT_ADDR, 16'h5000);
  endtask
  task automatic t_rw();
    host.wr(CFG_ADDR, 16'h2a00);
    rchk(CFG_ADDR, 16'h2a80);
    chk({9'h0, rw_field_o}, 16'h002a);
  endtask
  task automatic t_override();
    host.wr(EXT_ADDR, 16'h7000);
    chk({13'h0, cw_field_o}, 16'h0000);
    host.wr(EXT_ADDR, 16'h8000);
    host.wr(EXT_ADDR, 16'h5000);
    host.wr(EXT_ADDR, 16'h3000);
    chk({13'h0, cw_field_o}, 16'h0005);
    rchk(EXT_ADDR, 16'h5000);
  endtask
  task automatic t_write_zero();
    @(posedge core_clk_i);
    #1;
    fault_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    fault_i = 1'b0;
    host.wr(EXT_ADDR, 16'h0800);
    rchk(EXT_ADDR, 16'h5800);
    host.wr(EXT_ADDR, 16'h0000);
    rchk(EXT_ADDR, 16'h5000);
  endtask
  task automatic t_trigger();
    host.wr(CFG_ADDR, 16'haa00);
    @(posedge core_clk_i);
    #1;
    chk({15'h0, func_busy_o}, 16'h0001);
    rchk(CFG_ADDR, 16'haa80);
    for (int i = 0; i < 20 && func_busy_o !== 1'b0; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk({15'h0, func_busy_o}, 16'h0000);
    chk(starts[15:0], 16'h0001);
    rchk(CFG_ADDR, 16'h2a80);
  endtask
  // A second reset in mid-run, with a function running and fields away from defaults.
  task automatic t_reset();
    sm_state_i = 3'h0;
    host.wr(CFG_ADDR, 16'haa00);
    rstn_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    chk({15'h0, strap_o}, 16'h0000);
    chk({15'h0, func_busy_o}, 16'h0000);
    chk({9'h0, rw_field_o}, 16'h0000);
    chk({13'h0, cw_field_o}, 16'h0000);
    rchk(CFG_ADDR, 16'h0000);
    rchk(STAT_ADDR, 16'h4000);
  endtask
  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    strap_i = 1'b0;
    t_defaults();
    t_latches();
    t_rw();
    t_override();
    t_write_zero();
    t_trigger();
    t_reset();
    summarize();
  end
endmodule
